// *** ptu_pkg.sv ***
// Package: shared constants and types for the PWM timing update control block
package ptu_pkg;

    // Data width of period and timing parameter values
    localparam int unsigned PTU_DATA_W = 16;

    // Reset values
    localparam logic [PTU_DATA_W-1:0] PTU_PERIOD_RST = 16'h00ff;
    localparam logic [PTU_DATA_W-1:0] PTU_PARAM_RST  = 16'h0000;

    // Selects which buffered timing parameter a write targets
    typedef enum logic [2:0] {
        PTU_SEL_DUTY,
        PTU_SEL_SEC_DUTY,
        PTU_SEL_MASTER_DUTY,
        PTU_SEL_PHASE,
        PTU_SEL_SEC_PHASE,
        PTU_SEL_DEAD,
        PTU_SEL_ALT_DEAD
    } ptu_param_sel_t;

    // Set of timing parameters that follow the master period update timing
    typedef struct packed {
        logic [PTU_DATA_W-1:0] generator_duty;
        logic [PTU_DATA_W-1:0] secondary_duty;
        logic [PTU_DATA_W-1:0] master_duty;
        logic [PTU_DATA_W-1:0] phase;
        logic [PTU_DATA_W-1:0] secondary_phase;
        logic [PTU_DATA_W-1:0] dead_time;
        logic [PTU_DATA_W-1:0] alternate_dead_time;
    } ptu_params_t;

    localparam ptu_params_t PTU_PARAMS_RST = '{default: PTU_PARAM_RST};

    // One parameter write: strobe, target and value
    typedef struct packed {
        logic                  valid;
        ptu_param_sel_t        sel;
        logic [PTU_DATA_W-1:0] data;
    } ptu_param_wr_t;

    // Boundary-timed events
    typedef struct packed {
        logic fault_clear;
        logic climit_clear;
        logic ext_period_reset;
    } ptu_events_t;

endpackage : ptu_pkg

// *** ptu_update_ctrl.sv ***
// Module: PWM time base with buffered and immediate timing parameter updates
//
// Functional notes
// - Period, duty, dead-time and phase values may be rewritten at run time, one parameter per cycle alongside a period write.
// - With both immediate enables low, a master period and a parameter written in one cycle both apply at the next start.
// - The master period comes from the primary period when select is 0, secondary when 1.
// - All duty, phase and dead-time values are buffered and, with the immediate parameter enable low, follow the master period timing.
// - Dead-time compensation, fault and current-limit clears and external reset share that edge unless the immediate parameter enable is high.
// - With the immediate period enable high, a written master period applies at once.
// - With the immediate parameter enable high, parameter writes apply right after the write.
`timescale 1ns/1ps
`default_nettype none

module ptu_update_ctrl
    import ptu_pkg::*;
#(
    parameter int unsigned DATA_W = PTU_DATA_W
)
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // Period register writes
    input  wire logic                  primary_period_wr,
    input  wire logic                  secondary_period_wr,
    input  wire logic [DATA_W-1:0]     period_wdata,
    // Control bits
    input  wire logic                  time_base_select,
    input  wire logic                  immediate_period_update_en,
    input  wire logic                  immediate_param_update_en,
    // Timing parameter writes
    input  wire ptu_param_wr_t         param_wr,
    // Boundary-timed requests
    input  wire ptu_events_t           event_req,
    input  wire logic                  dt_comp_in,
    // Time base state
    output logic [DATA_W-1:0]          time_base_count,
    output logic                       cycle_boundary,
    output logic [DATA_W-1:0]          active_period,
    // Applied values and events
    output ptu_params_t                active_params,
    output ptu_events_t                event_apply,
    output logic                       dt_comp_active
);

    // Elaboration check
    if (DATA_W != PTU_DATA_W)
    begin : g_width_check
        $error("DATA_W must equal PTU_DATA_W");
    end

    // Applies one parameter write to a parameter set
    function automatic ptu_params_t apply_write(input ptu_params_t p, input ptu_param_wr_t w);
        ptu_params_t r;
        r = p;
        if (w.valid)
        begin
            unique case (w.sel)
                PTU_SEL_DUTY:        r.generator_duty      = w.data;
                PTU_SEL_SEC_DUTY:    r.secondary_duty      = w.data;
                PTU_SEL_MASTER_DUTY: r.master_duty         = w.data;
                PTU_SEL_PHASE:       r.phase               = w.data;
                PTU_SEL_SEC_PHASE:   r.secondary_phase     = w.data;
                PTU_SEL_DEAD:        r.dead_time           = w.data;
                PTU_SEL_ALT_DEAD:    r.alternate_dead_time = w.data;
                default:             r = p;
            endcase
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [DATA_W-1:0] count_reg, count_next;
    logic [DATA_W-1:0] primary_period_reg, primary_period_next;
    logic [DATA_W-1:0] secondary_period_reg, secondary_period_next;
    logic [DATA_W-1:0] period_reg, period_next;
    ptu_params_t       shadow_reg, shadow_next;
    ptu_params_t       params_reg, params_next;
    ptu_events_t       pend_reg, pend_next;
    ptu_events_t       apply_reg, apply_next;
    logic              dtc_reg, dtc_next;
    logic              boundary;
    logic              sel_period_wr;
    logic [DATA_W-1:0] sel_shadow_next;

    // Cycle boundary from the counter
    assign boundary = (count_reg >= period_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        // Time base counter
        count_next = boundary ? '0 : DATA_W'(count_reg + 1'b1);

        // Period shadows always take writes
        primary_period_next   = primary_period_wr ? period_wdata : primary_period_reg;
        secondary_period_next = secondary_period_wr ? period_wdata : secondary_period_reg;
        sel_shadow_next = time_base_select ? secondary_period_next : primary_period_next;
        sel_period_wr   = time_base_select ? secondary_period_wr : primary_period_wr;

        // Active master period
        if (immediate_period_update_en && sel_period_wr)
            period_next = period_wdata;
        else if (boundary)
            period_next = sel_shadow_next;
        else
            period_next = period_reg;

        // Timing parameter shadow and active set
        shadow_next = apply_write(shadow_reg, param_wr);
        if (immediate_param_update_en && param_wr.valid)
            params_next = apply_write(params_reg, param_wr);
        else if (boundary)
            params_next = shadow_next;
        else
            params_next = params_reg;

        // Boundary-timed events; a request in the boundary cycle applies there
        if (immediate_param_update_en)
        begin
            apply_next = event_req;
            pend_next  = '0;
        end
        else
        begin
            apply_next = boundary ? (pend_reg | event_req) : '0;
            pend_next  = boundary ? '0 : (pend_reg | event_req);
        end

        // Dead-time compensation level
        if (immediate_param_update_en)
            dtc_next = dt_comp_in;
        else if (boundary)
            dtc_next = dt_comp_in;
        else
            dtc_next = dtc_reg;
    end

    // Registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_reg            <= '0;
            primary_period_reg   <= PTU_PERIOD_RST;
            secondary_period_reg <= PTU_PERIOD_RST;
            period_reg           <= PTU_PERIOD_RST;
            shadow_reg           <= PTU_PARAMS_RST;
            params_reg           <= PTU_PARAMS_RST;
            pend_reg             <= '0;
            apply_reg            <= '0;
            dtc_reg              <= 1'b0;
        end
        else
        begin
            count_reg            <= count_next;
            primary_period_reg   <= primary_period_next;
            secondary_period_reg <= secondary_period_next;
            period_reg           <= period_next;
            shadow_reg           <= shadow_next;
            params_reg           <= params_next;
            pend_reg             <= pend_next;
            apply_reg            <= apply_next;
            dtc_reg              <= dtc_next;
        end
    end

    // Outputs
    assign time_base_count = count_reg;
    assign cycle_boundary  = boundary;
    assign active_period   = period_reg;
    assign active_params   = params_reg;
    assign event_apply     = apply_reg;
    assign dt_comp_active  = dtc_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence buffered_edge_s;
        boundary && !immediate_period_update_en && !sel_period_wr;
    endsequence

    sequence fault_req_mid_s;
        event_req.fault_clear && !immediate_param_update_en && !boundary;
    endsequence

    same_cycle_wr_a: assert property (
        (primary_period_wr && param_wr.valid && !immediate_param_update_en
            && !immediate_period_update_en && !boundary)
        |=> primary_period_reg == $past(period_wdata)
            && shadow_reg == $past(apply_write(shadow_reg, param_wr))
            && params_reg == $past(params_reg))
        else $error("same-cycle writes not both buffered");

    period_buffer_a: assert property (
        buffered_edge_s |=> period_reg == $past(sel_shadow_next))
        else $error("buffered period not applied at boundary");

    params_load_a: assert property (
        (boundary && !(immediate_param_update_en && param_wr.valid))
        |=> params_reg == $past(shadow_next))
        else $error("buffered parameters not applied at boundary");

    period_primary_a: assert property (
        (buffered_edge_s and !time_base_select) |=> period_reg == $past(primary_period_next))
        else $error("primary period not selected");

    period_secondary_a: assert property (
        (buffered_edge_s and time_base_select) |=> period_reg == $past(secondary_period_next))
        else $error("secondary period not selected");

    params_hold_a: assert property (
        (!boundary && !immediate_param_update_en) |=> $stable(params_reg))
        else $error("parameters changed between boundaries");

    event_edge_a: assert property (
        (apply_reg != '0) |-> $past(boundary) || $past(immediate_param_update_en))
        else $error("event applied off the boundary");

    event_keep_a: assert property (
        fault_req_mid_s |=> pend_reg.fault_clear)
        else $error("buffered fault clear lost");

    imm_period_a: assert property (
        (immediate_period_update_en && sel_period_wr) |=> period_reg == $past(period_wdata))
        else $error("immediate period not applied");

    imm_param_a: assert property (
        (immediate_param_update_en && param_wr.valid)
        |=> params_reg == $past(apply_write(params_reg, param_wr)))
        else $error("immediate parameter not applied");

    counter_wrap_a: assert property (
        boundary |=> count_reg == '0 ##1 (count_reg == 1 || $past(boundary)))
        else $error("counter did not restart at boundary");

endmodule : ptu_update_ctrl

`default_nettype wire

// *** ptu_update_ctrl_test.sv ***
// Testbench for the PWM timing update control block
`timescale 1ns/1ps
`default_nettype none

module ptu_update_ctrl_test;
import ptu_pkg::*;

logic              clk = 1'b0, rst_n = 1'b0;
logic              pri_wr = 1'b0, sec_wr = 1'b0, sel = 1'b0;
logic              imm_per = 1'b0, imm_par = 1'b0, dt_in = 1'b0;
logic [15:0]       wdata = 16'h0000, count, period;
ptu_param_wr_t     param_wr = '0;
ptu_events_t       ev_req = '0, ev_app;
ptu_params_t       params;
logic              bound, dt_act;
int                errors = 0, total_checks = 0, cycles = 0;
logic [111:0]      exp_p;

ptu_update_ctrl ptu_update_ctrl_i (.clk(clk), .rst_n(rst_n), .primary_period_wr(pri_wr),
    .secondary_period_wr(sec_wr), .period_wdata(wdata), .time_base_select(sel),
    .immediate_period_update_en(imm_per), .immediate_param_update_en(imm_par),
    .param_wr(param_wr), .event_req(ev_req), .dt_comp_in(dt_in),
    .time_base_count(count), .cycle_boundary(bound), .active_period(period),
    .active_params(params), .event_apply(ev_app), .dt_comp_active(dt_act));

// Clock and hang guard
always #25 clk = ~clk;
always @(posedge clk)
begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
        errors++;
        stop_test();
    end
end

////////////////////////////////////////////////////////////////////////////////
task automatic step();
    @(posedge clk);
    #1;
endtask

task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
        errors++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
endtask

task automatic wr_period(input logic second, input logic [15:0] d);
    pri_wr = ~second;
    sec_wr = second;
    wdata  = d;
    step();
    pri_wr = 1'b0;
    sec_wr = 1'b0;
endtask

task automatic wr_param(input ptu_param_sel_t s, input logic [15:0] d);
    param_wr = {1'b1, s, d};
    step();
    param_wr.valid = 1'b0;
    step();
endtask

// Waits for the boundary cycle, then passes the edge that applies updates
task automatic to_edge();
    int n;
    n = 0;
    while (bound !== 1'b1 && n < 400)
    begin
        step();
        n++;
    end
    step();
endtask

////////////////////////////////////////////////////////////////////////////////
// Period and all parameters written before one boundary apply together
task automatic t_buffered();
    int i;
    chk(period, 16'h00ff);
    // First duty write shares the cycle of the period write
    param_wr = {1'b1, PTU_SEL_DUTY, 16'h00a0};
    exp_p[111:96] = 16'h00a0;
    wr_period(1'b0, 16'h0005);
    for (i = 1; i < 7; i++)
    begin
        wr_param(ptu_param_sel_t'(i), 16'h00a0 + 16'(i));
        exp_p[(6-i)*16 +: 16] = 16'h00a0 + 16'(i);
    end
    chk(period, 16'h00ff);
    chk(params.generator_duty, 16'h0000);
    to_edge();
    chk(period, 16'h0005);
    for (i = 0; i < 7; i++)
        chk(params[(6-i)*16 +: 16], exp_p[(6-i)*16 +: 16]);
    chk(count, 16'h0000);
    repeat (5) step();
    chk({count[14:0], bound}, 16'h000b);
    $display("test buffered done");
endtask

// Secondary period becomes master when selected
task automatic t_select();
    wr_period(1'b1, 16'h0003);
    sel = 1'b1;
    to_edge();
    chk(period, 16'h0003);
    $display("test select done");
endtask

// Immediate period and parameter writes, immediate event
task automatic t_immediate();
    imm_per = 1'b1;
    wr_period(1'b1, 16'h0008);
    chk(period, 16'h0008);
    imm_per = 1'b0;
    imm_par = 1'b1;
    wr_param(PTU_SEL_ALT_DEAD, 16'h0011);
    chk(params.alternate_dead_time, 16'h0011);
    ev_req = 3'b100;
    step();
    ev_req = '0;
    chk({13'h0000, ev_app}, 16'h0004);
    step();
    imm_par = 1'b0;
    chk({13'h0000, ev_app}, 16'h0000);
    $display("test immediate done");
endtask

// Clears, period reset and compensation wait for the boundary
task automatic t_events();
    while (count !== 16'h0001)
        step();
    ev_req = 3'b111;
    dt_in  = 1'b1;
    step();
    ev_req = '0;
    chk({12'h000, dt_act, ev_app}, 16'h0000);
    to_edge();
    chk({12'h000, dt_act, ev_app}, 16'h000f);
    step();
    chk({13'h0000, ev_app}, 16'h0000);
    $display("test events done");
endtask

task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask

// Main sequence
initial
begin
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    step();
    t_buffered();
    t_select();
    t_immediate();
    t_events();
    stop_test();
end

endmodule // ptu_update_ctrl_test

`default_nettype wire
